/* power_seq_regs.svh */
`ifndef POWER_SEQ_REGS_SVH
`define POWER_SEQ_REGS_SVH

`define CLK_HZ 20000000
`define ON_HOLD_MS 5000
`define OFF_HOLD_MS 3000
`define EMERG_HOLD_MS 200
`define CYC_PER_MS (`CLK_HZ / 1000)
`define ON_HOLD_CYC (`ON_HOLD_MS * `CYC_PER_MS)
`define OFF_HOLD_CYC (`OFF_HOLD_MS * `CYC_PER_MS)
`define EMERG_HOLD_CYC (`EMERG_HOLD_MS * `CYC_PER_MS)
`define BOOT_CYC 16

`endif

/* power_seq_pkg.sv */
package power_seq_pkg;
	typedef enum logic [2:0] {
		ST_OFF,
		ST_BOOT,
		ST_ON,
		ST_DETACH,
		ST_HALT
	} pwr_state_e;

	typedef struct packed {
		logic detach_req;
		logic power_good_out;
	} status_s;
endpackage

/* module_power_sequencing.sv */
`timescale 1ns/1ps
`include "power_seq_regs.svh"

module module_power_sequencing #(
	parameter int unsigned ON_HOLD_CYC = `ON_HOLD_CYC,
	parameter int unsigned OFF_HOLD_CYC = `OFF_HOLD_CYC,
	parameter int unsigned EMERG_HOLD_CYC = `EMERG_HOLD_CYC
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	// Control pads, as seen after the internal pull-up
	input wire logic power_toggle_n,
	input wire logic emergency_off_n,
	// Software shutdown and detach handshake
	input wire logic shutdown_command,
	input wire logic detach_done,
	// Status
	output power_seq_pkg::status_s status,
	output power_seq_pkg::pwr_state_e state
);
	import power_seq_pkg::*;

	localparam int CW = 32;

	////////////////////////////////////////////////////////////////////////////
	// Pad synchronisers
	logic [1:0] tog_sync_q;
	logic [1:0] emg_sync_q;
	logic tog_low;
	logic emg_low;

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			tog_sync_q <= 2'h3;
			emg_sync_q <= 2'h3;
		end else begin
			tog_sync_q <= {tog_sync_q[0], power_toggle_n};
			emg_sync_q <= {emg_sync_q[0], emergency_off_n};
		end
	end
	assign tog_low = !tog_sync_q[1];
	assign emg_low = !emg_sync_q[1];

	////////////////////////////////////////////////////////////////////////////
	// Low-time counters
	logic [CW-1:0] tog_cnt_q;
	logic [CW-1:0] emg_cnt_q;
	logic tog_rel;
	logic emg_rel;

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			tog_cnt_q <= '0;
		end else if (tog_low) begin
			if (tog_cnt_q != '1) begin
				tog_cnt_q <= tog_cnt_q + 32'h1;
			end
		end else begin
			tog_cnt_q <= '0;
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			emg_cnt_q <= '0;
		end else if (emg_low) begin
			if (emg_cnt_q != '1) begin
				emg_cnt_q <= emg_cnt_q + 32'h1;
			end
		end else begin
			emg_cnt_q <= '0;
		end
	end

	// Release seen after the pad went high again
	assign tog_rel = !tog_low && tog_cnt_q != '0;
	assign emg_rel = !emg_low && emg_cnt_q >= EMERG_HOLD_CYC;

	////////////////////////////////////////////////////////////////////////////
	// Sequencer
	pwr_state_e state_q;
	logic [4:0] boot_q;
	logic detach_q;
	logic good_q;

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			state_q <= ST_OFF;
			boot_q <= '0;
		end else if (emg_rel) begin
			// Emergency off, no detach, no restart
			state_q <= ST_OFF;
			boot_q <= '0;
		end else begin
			unique case (state_q)
				ST_OFF: begin
					if (tog_rel && tog_cnt_q >= ON_HOLD_CYC) begin
						state_q <= ST_BOOT;
						boot_q <= '0;
					end
				end
				ST_BOOT: begin
					boot_q <= boot_q + 5'h1;
					if (boot_q == 5'(`BOOT_CYC - 1)) begin
						state_q <= ST_ON;
					end
				end
				ST_ON: begin
					if (shutdown_command || (tog_rel && tog_cnt_q >= OFF_HOLD_CYC)) begin
						state_q <= ST_DETACH;
					end
				end
				ST_DETACH: begin
					if (detach_done) begin
						state_q <= ST_HALT;
					end
				end
				ST_HALT: begin
					state_q <= ST_OFF;
				end
			endcase
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			detach_q <= 1'b0;
		end else begin
			detach_q <= !emg_rel && (state_q == ST_DETACH) && !detach_done;
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			good_q <= 1'b0;
		end else begin
			good_q <= !emg_rel && (state_q == ST_BOOT || state_q == ST_ON || state_q == ST_DETACH);
		end
	end

	assign status = '{detach_req: detach_q, power_good_out: good_q};
	assign state = state_q;

	////////////////////////////////////////////////////////////////////////////
	// Checks
	// Power-good low while off
	a_good_tracks_state: assert property (@(posedge mclk) disable iff (!rst_n)
		$past(state_q) == ST_OFF && state_q == ST_OFF |-> !good_q)
		else $error("power good high while off");

	a_good_while_on: assert property (@(posedge mclk) disable iff (!rst_n)
		$past(state_q) == ST_ON && state_q == ST_ON |-> good_q)
		else $error("power good low while on");

	a_emerg_no_detach: assert property (@(posedge mclk) disable iff (!rst_n)
		emg_rel |=> !detach_q && state_q == ST_OFF)
		else $error("emergency off detached or stayed on");

	a_no_self_start: assert property (@(posedge mclk) disable iff (!rst_n)
		state_q == ST_OFF && !tog_rel |=> state_q == ST_OFF)
		else $error("left off without a press");

	a_short_no_on: assert property (@(posedge mclk) disable iff (!rst_n)
		state_q == ST_OFF && tog_rel && tog_cnt_q < ON_HOLD_CYC && !emg_rel |=> state_q == ST_OFF)
		else $error("short press powered on");

	sequence s_on_release;
		state_q == ST_OFF && tog_rel && tog_cnt_q >= ON_HOLD_CYC && !emg_rel;
	endsequence
	sequence s_boot_good;
		state_q == ST_BOOT ##1 (good_q || $past(emg_rel));
	endsequence
	sequence s_detach_entered;
		state_q == ST_DETACH ##1 (detach_q || $past(detach_done) || $past(emg_rel));
	endsequence

	a_power_on_seq: assert property (@(posedge mclk) disable iff (!rst_n)
		s_on_release |=> s_boot_good)
		else $error("long press did not start boot");

	a_off_via_detach: assert property (@(posedge mclk) disable iff (!rst_n)
		state_q == ST_HALT |-> $past(state_q) == ST_DETACH)
		else $error("halt without detach");

	a_detach_held: assert property (@(posedge mclk) disable iff (!rst_n)
		state_q == ST_DETACH && !detach_done && !emg_rel |=> detach_q)
		else $error("detach request dropped early");

	// Long press in on starts detach
	a_long_press_off: assert property (@(posedge mclk) disable iff (!rst_n)
		state_q == ST_ON && tog_rel && tog_cnt_q >= OFF_HOLD_CYC && !emg_rel |=> s_detach_entered)
		else $error("long press did not detach");
endmodule // module_power_sequencing

/* host_pad_model.sv */
`timescale 1ns/1ps
module host_pad_model #(
	parameter int GUARD_CYC = 10
) (
	// Clock
	input wire logic mclk,
	// Module status
	input wire logic power_good,
	// Pad levels
	output logic power_toggle_n,
	output logic emergency_off_n
);
	logic tog_oe = 1'h0;
	logic emg_oe = 1'h0;
	logic main_supply_ok = 1'h0;
	logic serial_ok = 1'h0;
	int guard_cnt = 0;
	assign power_toggle_n = !tog_oe;
	assign emergency_off_n = !emg_oe;
	initial begin
		repeat (4) @(posedge mclk);
		main_supply_ok <= 1'h1;
	end
	always @(posedge mclk) begin
		if (power_good !== 1'h1) begin
			guard_cnt <= 0;
			serial_ok <= 1'h0;
		end else if (guard_cnt < GUARD_CYC) begin
			guard_cnt <= guard_cnt + 1;
		end else begin
			serial_ok <= 1'h1;
		end
	end
	task automatic press_toggle(input int n);
		@(posedge mclk) tog_oe <= 1'h1;
		repeat (n) @(posedge mclk);
		tog_oe <= 1'h0;
	endtask
	// power-on press once supply is good
	task automatic press_on(input int n);
		wait (main_supply_ok === 1'h1);
		press_toggle(n);
	endtask
	task automatic press_emerg(input int n);
		@(posedge mclk) emg_oe <= 1'h1;
		repeat (n) @(posedge mclk);
		emg_oe <= 1'h0;
	endtask
endmodule // host_pad_model

/* module_power_sequencing_bench.sv */
`timescale 1ns/1ps
module module_power_sequencing_bench;
	import power_seq_pkg::*;
	logic mclk = 1'h0;
	logic rst_n = 1'h0;
	logic shutdown_command = 1'h0;
	logic detach_done = 1'h0;
	wire logic power_toggle_n;
	wire logic emergency_off_n;
	status_s status;
	pwr_state_e state;
	int n_mismatch = 0;
	int tests_run = 0;
	always #25 mclk = ~mclk;
	host_pad_model host (
		.mclk(mclk),
		.power_good(status.power_good_out),
		.power_toggle_n(power_toggle_n),
		.emergency_off_n(emergency_off_n)
	);
	module_power_sequencing #(.ON_HOLD_CYC(20), .OFF_HOLD_CYC(12), .EMERG_HOLD_CYC(4)) dut (
		.mclk(mclk),
		.rst_n(rst_n),
		.power_toggle_n(power_toggle_n),
		.emergency_off_n(emergency_off_n),
		.shutdown_command(shutdown_command),
		.detach_done(detach_done),
		.status(status),
		.state(state)
	);
	task automatic check(input string what, input logic exp, input logic got);
		tests_run++;
		if (got !== exp) begin
			n_mismatch++;
			$display("MISMATCH %s expected %0h seen %0h", what, exp, got);
		end
	endtask
	task automatic summarize();
		$display("checks %0d mismatches %0d", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task automatic wait_cyc(input int n);
		repeat (n) @(negedge mclk);
	endtask
	task automatic power_on();
		host.press_on(22);
		wait_cyc(6);
		check("good_boot", 1'h1, status.power_good_out);
		check("boot", 1'h1, state === ST_BOOT);
		check("guard_early", 1'h0, host.serial_ok);
		wait_cyc(25);
		check("on", 1'h1, state === ST_ON);
		check("guard_open", 1'h1, host.serial_ok);
	endtask
	task automatic t_short_press();
		host.press_toggle(10);
		wait_cyc(30);
		check("short_off", 1'h1, state === ST_OFF);
		check("short_good", 1'h0, status.power_good_out);
	endtask
	task automatic detach_end();
		wait_cyc(5);
		check("detach_req", 1'h1, status.detach_req);
		@(posedge mclk) detach_done <= 1'h1;
		@(posedge mclk) detach_done <= 1'h0;
		wait_cyc(5);
		check("off", 1'h1, state === ST_OFF);
		check("good_off", 1'h0, status.power_good_out);
	endtask
	task automatic t_command_off();
		power_on();
		@(posedge mclk) shutdown_command <= 1'h1;
		@(posedge mclk) shutdown_command <= 1'h0;
		detach_end();
	endtask
	task automatic t_toggle_off();
		power_on();
		host.press_toggle(14);
		detach_end();
	endtask
	task automatic t_emergency();
		power_on();
		host.press_emerg(2);
		wait_cyc(8);
		check("emerg_short", 1'h1, state === ST_ON);
		host.press_emerg(6);
		wait_cyc(6);
		check("emerg_off", 1'h1, state === ST_OFF);
		check("emerg_detach", 1'h0, status.detach_req);
		wait_cyc(40);
		check("no_restart", 1'h0, status.power_good_out);
		power_on();
	endtask
	task automatic t_reset_mid();
		@(posedge mclk) rst_n <= 1'h0;
		wait_cyc(2);
		check("rst_state", 1'h1, state === ST_OFF);
		check("rst_good", 1'h0, status.power_good_out);
		check("rst_guard", 1'h0, host.serial_ok);
		@(posedge mclk) rst_n <= 1'h1;
		wait_cyc(2);
		check("rst_idle", 1'h1, state === ST_OFF);
		power_on();
	endtask
	initial begin
		repeat (8) @(posedge mclk);
		rst_n <= 1'h1;
		wait_cyc(2);
		t_short_press();
		t_command_off();
		t_toggle_off();
		t_emergency();
		t_reset_mid();
		summarize();
	end
	initial begin
		wait_cyc(2000);
		n_mismatch++;
		summarize();
	end
endmodule // module_power_sequencing_bench
